// File: hw/ccseq_consts.svh
// timing counts and register layout for the charge cycle sequencer
`ifndef CCSEQ_CONSTS_SVH
`define CCSEQ_CONSTS_SVH
`define CCSEQ_CLK_MHZ 200
`define CCSEQ_T_SS_HOLD_MS 80
`define CCSEQ_T_SS_STEP_US 256
`define CCSEQ_T_TERM_MS 32
`define CCSEQ_T_OVP_MS 1
`define CCSEQ_T_START_MS 64
`define CCSEQ_SS_HOLD_CYC (`CCSEQ_T_SS_HOLD_MS * 1000 * `CCSEQ_CLK_MHZ)
`define CCSEQ_SS_STEP_CYC (`CCSEQ_T_SS_STEP_US * `CCSEQ_CLK_MHZ)
`define CCSEQ_TERM_CYC (`CCSEQ_T_TERM_MS * 1000 * `CCSEQ_CLK_MHZ)
`define CCSEQ_OVP_CYC (`CCSEQ_T_OVP_MS * 1000 * `CCSEQ_CLK_MHZ)
`define CCSEQ_START_CYC (`CCSEQ_T_START_MS * 1000 * `CCSEQ_CLK_MHZ)
`define CCSEQ_ADDR_CTRL 8'h02
`define CCSEQ_ADDR_STAT 8'h00
`define CCSEQ_ADDR_VREG 8'h03
`define CCSEQ_CTRL_RESET 0
`define CCSEQ_CTRL_INHIBIT 1
`define CCSEQ_CTRL_TERM_ALLOW 2
`define CCSEQ_CTRL_HIZ 3
`define CCSEQ_CTRL_REDUCED 4
`define CCSEQ_CTRL_RST_VAL 8'h04
`define CCSEQ_VREG_MIN 8'h00
`define CCSEQ_VREG_MAX 8'h2F
`define CCSEQ_VREG_RST_VAL 8'h05
`define CCSEQ_ILIM_100MA 3'h0
`define CCSEQ_PCT_40 7'h28
`define CCSEQ_PCT_100 7'h64
`endif

// File: hw/ccseq_pkg.sv
// types shared by the charge cycle sequencer
package ccseq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SHORT,
    ST_CHARGE,
    ST_DETECT,
    ST_DONE,
    ST_OVP
  } ccseq_state_e;

  // comparator and loop indications, already synchronised and deglitched
  typedef struct packed {
    logic supply_ok;
    logic below_short;
    logic below_recharge;
    logic below_term;
    logic above_ovp;
    logic die_hot;
    logic supplement;
    logic ts_half;
    logic rev_boost;
    logic vin_floor;
    logic input_loop;
    logic cv_loop;
  } ccseq_sense_s;

  // power stage commands
  typedef struct packed {
    logic pwm_on;
    logic charge_fet;
    logic batt_fet;
    logic short_current;
    logic thermal_fold;
    logic supplement_mode;
    logic sys_reg_mode;
    logic detect;
    logic [6:0] ilim_pct;
  } ccseq_drive_s;
endpackage

// File: hw/ccseq_top.sv
// charge cycle sequencer: soft start, charge, termination, overvoltage
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/10ps
`include "ccseq_consts.svh"
module ccseq_top
  import ccseq_pkg::*;
#(
  parameter int SS_HOLD_CYC = `CCSEQ_SS_HOLD_CYC,
  parameter int SS_STEP_CYC = `CCSEQ_SS_STEP_CYC,
  parameter int TERM_CYC = `CCSEQ_TERM_CYC,
  parameter int OVP_CYC = `CCSEQ_OVP_CYC,
  parameter int START_CYC = `CCSEQ_START_CYC
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic CHARGE_INHIBIT_PIN,
  input wire logic [2:0] ILIM_SEL,
  input wire ccseq_sense_s SENSE,
  output ccseq_drive_s DRIVE,
  output logic [7:0] BATTERY_REGULATION_VOLTAGE,
  output logic BATTERY_OVERVOLTAGE_FAULT
);

  // ---------------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] vreg;
  ccseq_state_e state;
  ccseq_state_e next_state;
  logic [31:0] ss_cnt;
  logic [2:0] ss_step;
  logic ss_done;
  logic [31:0] term_cnt;
  logic [31:0] ovp_cnt;
  logic [31:0] start_cnt;
  logic fault;
  logic hiz_q;
  logic pin_q;
  logic inh_q;
  logic rst_q;
  logic supply_q;
  logic batt_q;
  logic supp_q;

  // counter compare helper used by several timers
  function automatic logic reached(input logic [31:0] cnt, input int lim);
    reached = (cnt >= 32'(lim - 1));
  endfunction

  // ---------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------
  wire wr_ctrl = WR && (ADDR == `CCSEQ_ADDR_CTRL);
  wire wr_vreg = WR && (ADDR == `CCSEQ_ADDR_VREG);
  wire hiz = ctrl[`CCSEQ_CTRL_HIZ] || CHARGE_INHIBIT_PIN;
  wire inhibit = ctrl[`CCSEQ_CTRL_INHIBIT] || CHARGE_INHIBIT_PIN;
  wire hiz_enter = hiz && !hiz_q;
  // inputs in SENSE are already clean, so edge tests read them directly
  wire batt_ok = !SENSE.below_recharge;
  wire bit_toggle = (ctrl[`CCSEQ_CTRL_INHIBIT] != inh_q) ||
    (ctrl[`CCSEQ_CTRL_RESET] != rst_q);
  wire pin_toggle = (CHARGE_INHIBIT_PIN != pin_q) ||
    (ctrl[`CCSEQ_CTRL_HIZ] != hiz_q);
  wire supp_event = SENSE.supplement && !supp_q;
  wire new_cycle = !CHARGE_INHIBIT_PIN && SENSE.below_recharge &&
    ((SENSE.supply_ok && !supply_q) ||
     (SENSE.supply_ok && !batt_q));
  wire recharge = SENSE.supply_ok && !SENSE.above_ovp &&
    (SENSE.below_recharge || bit_toggle || supp_event ||
     pin_toggle);
  // any limiting loop other than voltage regulation blocks termination
  wire term_block = !SENSE.cv_loop || SENSE.ts_half || SENSE.rev_boost ||
    ctrl[`CCSEQ_CTRL_REDUCED] || SENSE.die_hot || SENSE.vin_floor ||
    SENSE.input_loop || (ILIM_SEL == `CCSEQ_ILIM_100MA);
  wire term_qual = batt_ok && SENSE.below_term && !SENSE.supplement &&
    !term_block && ctrl[`CCSEQ_CTRL_TERM_ALLOW];
  // qualified by the live comparator so a drop on the last cycle never sets
  wire ovp_seen = SENSE.above_ovp && reached(ovp_cnt, OVP_CYC);
  wire run = SENSE.supply_ok && !hiz && !inhibit;

  // ---------------------------------------------------------------------
  // sequencer transitions
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (run && (new_cycle || recharge || batt_ok))
          next_state = ST_WAIT;
      ST_WAIT:
        if (!run)
          next_state = ST_IDLE;
        else if (reached(start_cnt, START_CYC))
          next_state = SENSE.below_short ? ST_SHORT : ST_CHARGE;
      ST_SHORT:
        if (!run)
          next_state = ST_IDLE;
        else if (!SENSE.below_short)
          next_state = ST_CHARGE;
      ST_CHARGE:
        if (!run)
          next_state = ST_IDLE;
        else if (term_qual && reached(term_cnt, TERM_CYC))
          next_state = ST_DETECT;
      ST_DETECT:
        if (!run)
          next_state = ST_IDLE;
        else
          next_state = ST_DONE;
      ST_DONE:
        if (!run)
          next_state = ST_IDLE;
        else if (recharge)
          next_state = ST_WAIT;
      // stay put until the battery is back down, not just until reported
      ST_OVP:
        if (!fault && !SENSE.above_ovp)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    if (SENSE.above_ovp && state != ST_OVP)
      next_state = ST_OVP;
  end

  // ---------------------------------------------------------------------
  // state and timers, frozen while CE is low
  // ---------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      start_cnt <= 32'h0000_0000;
      term_cnt <= 32'h0000_0000;
      ovp_cnt <= 32'h0000_0000;
    end
    else if (CE)
    begin
      state <= next_state;
      start_cnt <= (state == ST_WAIT) ? start_cnt + 32'h1 : 32'h0;
      // any disturbance restarts the 32ms window
      term_cnt <= (state == ST_CHARGE && term_qual) ?
        term_cnt + 32'h1 : 32'h0;
      ovp_cnt <= (SENSE.above_ovp && !ovp_seen) ? ovp_cnt + 32'h1 :
        (SENSE.above_ovp ? ovp_cnt : 32'h0);
    end
  end

  // soft start: ramp restarts only on high impedance exit
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ss_cnt <= 32'h0000_0000;
      ss_step <= 3'h0;
      ss_done <= 1'b0;
    end
    else if (CE)
    begin
      if (hiz)
      begin
        ss_cnt <= 32'h0000_0000;
        ss_step <= 3'h0;
        ss_done <= 1'b0;
      end
      else if (!ss_done)
      begin
        if ((ss_step == 3'h0 && reached(ss_cnt, SS_HOLD_CYC)) ||
            (ss_step != 3'h0 && reached(ss_cnt, SS_STEP_CYC)))
        begin
          ss_cnt <= 32'h0000_0000;
          ss_step <= ss_step + 3'h1;
          ss_done <= (ss_step == 3'h4);
        end
        else
          ss_cnt <= ss_cnt + 32'h1;
      end
    end
  end

  // fault flag: set wins over clear
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      fault <= 1'b0;
    else if (CE)
    begin
      if (ovp_seen)
        fault <= 1'b1;
      else if (SENSE.below_recharge || hiz_enter)
        fault <= 1'b0;
    end
  end

  // edge history for toggle and arrival detection
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      hiz_q <= 1'b0;
      pin_q <= 1'b0;
      inh_q <= 1'b0;
      rst_q <= 1'b0;
      supply_q <= 1'b0;
      batt_q <= 1'b0;
      supp_q <= 1'b0;
    end
    else if (CE)
    begin
      hiz_q <= hiz;
      pin_q <= CHARGE_INHIBIT_PIN;
      inh_q <= ctrl[`CCSEQ_CTRL_INHIBIT];
      rst_q <= ctrl[`CCSEQ_CTRL_RESET];
      supply_q <= SENSE.supply_ok;
      batt_q <= SENSE.below_recharge;
      supp_q <= SENSE.supplement;
    end
  end

  // ---------------------------------------------------------------------
  // register port; every regulation code is accepted
  // ---------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ctrl <= `CCSEQ_CTRL_RST_VAL;
      vreg <= `CCSEQ_VREG_RST_VAL;
      RDATA <= 8'h00;
    end
    else if (CE)
    begin
      if (wr_ctrl)
        ctrl <= WDATA;
      if (wr_vreg)
        vreg <= WDATA;
      if (RD)
        case (ADDR)
          `CCSEQ_ADDR_CTRL: RDATA <= ctrl;
          `CCSEQ_ADDR_VREG: RDATA <= vreg;
          `CCSEQ_ADDR_STAT: RDATA <= {fault, ss_done, 3'h0, 3'(state)};
          default: RDATA <= 8'h00;
        endcase
    end
  end

  // ---------------------------------------------------------------------
  // power stage commands
  // ---------------------------------------------------------------------
  wire [6:0] ss_pct = ss_done ? `CCSEQ_PCT_100 :
    7'(`CCSEQ_PCT_40 + 7'(ss_step) * 7'h0A);
  wire charging = (state == ST_CHARGE) || (state == ST_SHORT);
  wire done = (state == ST_DONE) || (state == ST_DETECT);
  always_comb
  begin
    // the live comparator cuts the converter before the state flop follows
    DRIVE.pwm_on = (state != ST_OVP) && !SENSE.above_ovp &&
      SENSE.supply_ok && !hiz;
    DRIVE.charge_fet = charging;
    DRIVE.batt_fet = (state == ST_OVP) || SENSE.above_ovp ||
      SENSE.supplement || hiz;
    DRIVE.short_current = (state == ST_SHORT);
    DRIVE.thermal_fold = charging && SENSE.die_hot;
    DRIVE.supplement_mode = SENSE.supplement;
    DRIVE.sys_reg_mode = done || (state == ST_SHORT);
    DRIVE.detect = (state == ST_DETECT);
    DRIVE.ilim_pct = done ? `CCSEQ_PCT_100 : ss_pct;
  end

  assign BATTERY_REGULATION_VOLTAGE = vreg;
  assign BATTERY_OVERVOLTAGE_FAULT = fault;

endmodule

// File: test/ccseq_top_asserts.sv
// port assertions for the charge cycle sequencer
`timescale 1ns/10ps
module ccseq_top_asserts
  import ccseq_pkg::*;
#(
  parameter int SS_STEP_CYC = 8,
  parameter int TERM_CYC = 16,
  parameter int OVP_CYC = 10
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WR,
  input wire logic CHARGE_INHIBIT_PIN,
  input wire logic [2:0] ILIM_SEL,
  input wire ccseq_sense_s SENSE,
  input wire ccseq_drive_s DRIVE,
  input wire logic BATTERY_OVERVOLTAGE_FAULT
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N || !CE);
  int ovp_run;
  int term_run;
  int hold;
  logic [6:0] last_pct;
  logic term_ok;
  // low current, no loop or supplement in the way, limit not 100mA
  assign term_ok = SENSE.below_term && !SENSE.below_recharge
    && !(|SENSE[6:1]) && ILIM_SEL != 3'h0;
  // run lengths behind the timed events
  always_ff @(posedge CLOCK)
  begin
    ovp_run <= (RST_N && SENSE.above_ovp) ? ovp_run + 1 : 0;
    term_run <= (RST_N && term_ok) ? term_run + 1 : 0;
    hold <= (!RST_N || DRIVE.ilim_pct != last_pct) ? 0 : hold + 1;
    last_pct <= DRIVE.ilim_pct;
  end
  a_step_size_time:
    assert property (DRIVE.ilim_pct != last_pct
      && last_pct inside {7'h32, 7'h3C, 7'h46, 7'h50}
      |-> hold inside {[SS_STEP_CYC-2:SS_STEP_CYC]}
      && DRIVE.ilim_pct == last_pct + (last_pct == 7'h50 ? 20 : 10))
    else $error("bad soft start step");
  a_ss_stays_done:
    assert property (last_pct == 7'h64 && DRIVE.ilim_pct != 7'h64
      |-> $past(CHARGE_INHIBIT_PIN) || $past(CHARGE_INHIBIT_PIN, 2)
      || $past(WR) || $past(WR, 2))
    else $error("soft start restarted");
  a_fault_not_early:
    assert property ($rose(BATTERY_OVERVOLTAGE_FAULT)
      |-> ovp_run >= OVP_CYC - 1)
    else $error("fault too early");
  a_fault_not_late:
    assert property (ovp_run == OVP_CYC + 2 |-> BATTERY_OVERVOLTAGE_FAULT)
    else $error("fault missing");
  a_fault_clear_low:
    assert property (BATTERY_OVERVOLTAGE_FAULT && SENSE.below_recharge
      && !SENSE.above_ovp |-> ##[1:2] !BATTERY_OVERVOLTAGE_FAULT)
    else $error("fault kept when low");
  a_fault_clear_hiz:
    assert property ($rose(CHARGE_INHIBIT_PIN) && !SENSE.above_ovp
      |-> ##[1:2] !BATTERY_OVERVOLTAGE_FAULT)
    else $error("fault kept in hiz");
  a_ovp_stops_pwm:
    assert property (SENSE.above_ovp |-> !DRIVE.pwm_on && DRIVE.batt_fet)
    else $error("converter on in ovp");
  a_term_qualified:
    assert property ($rose(DRIVE.detect) |-> term_run >= TERM_CYC - 1)
    else $error("unqualified termination");
endmodule

// File: test/ccseq_host.sv
// host model driving the register port of the sequencer
`timescale 1ns/10ps
`include "ccseq_consts.svh"
module ccseq_host
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr = 8'h00,
  output logic [7:0] wdata = 8'h00,
  output logic wr_s = 1'b0,
  output logic rd_s = 1'b0
);
  // one strobe cycle, dropped at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // data is registered at the strobe edge and held until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // regulation only changed from high impedance, never below battery
  task automatic set_vreg(input logic [7:0] code);
    wr(`CCSEQ_ADDR_CTRL, `CCSEQ_CTRL_RST_VAL | 8'h08);
    wr(`CCSEQ_ADDR_VREG, code);
    wr(`CCSEQ_ADDR_CTRL, `CCSEQ_CTRL_RST_VAL);
  endtask
endmodule

// File: test/tb_ccseq_top.sv
// self-checking bench for the charge cycle sequencer
`timescale 1ns/10ps
`include "ccseq_consts.svh"
module tb_ccseq_top
  import ccseq_pkg::*;
;
  localparam int HOLD = 20;
  localparam int STEP = 8;
  localparam int TERM = 16;
  localparam int OVP = 10;
  localparam int START = 12;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b1;
  logic ce = 1'b1;
  logic [2:0] ilim = 3'h5;
  logic [7:0] addr, wdata, rdata, vreg, got, e;
  logic wr, rd, fault;
  ccseq_sense_s sense = '0;
  // supply, low current, voltage loop in control: termination qualifies
  ccseq_sense_s base = 12'h901;
  ccseq_drive_s drive;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  // 200 MHz
  always #2.5 clk = ~clk;
  ccseq_top #(.SS_HOLD_CYC(HOLD), .SS_STEP_CYC(STEP), .TERM_CYC(TERM),
    .OVP_CYC(OVP), .START_CYC(START)) u_ccseq_top (.CLOCK(clk),
    .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CHARGE_INHIBIT_PIN(pin), .ILIM_SEL(ilim), .SENSE(sense),
    .DRIVE(drive), .BATTERY_REGULATION_VOLTAGE(vreg),
    .BATTERY_OVERVOLTAGE_FAULT(fault));
  ccseq_host u_ccseq_host (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr_s(wr), .rd_s(rd));
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x)
    begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, g, x);
    end
  endtask
  // status read, masked
  task automatic cs(input logic [7:0] m, input logic [7:0] x);
    u_ccseq_host.rd(`CCSEQ_ADDR_STAT, got);
    chk(got & m, x);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(26));
    step(20);
    rst_n <= 1'b1;
    // read-only status, unmapped hole, defaults
    u_ccseq_host.wr(`CCSEQ_ADDR_STAT, 8'hFF);
    u_ccseq_host.wr(8'h7F, 8'hFF);
    u_ccseq_host.rd(8'h7F, got);
    chk(got, 8'h00);
    // clock enable low: the write must not be taken
    ce <= 1'b0;
    u_ccseq_host.wr(`CCSEQ_ADDR_CTRL, 8'hFF);
    ce <= 1'b1;
    u_ccseq_host.rd(`CCSEQ_ADDR_CTRL, got);
    chk(got, `CCSEQ_CTRL_RST_VAL);
    u_ccseq_host.rd(`CCSEQ_ADDR_VREG, got);
    chk(got, `CCSEQ_VREG_RST_VAL);
    cs(8'hFF, 8'h00);
    $display("test registers done");
    // supply with a shorted battery, high impedance released
    sense <= 12'hE00;
    pin <= 1'b0;
    step(START + 4);
    cs(8'h07, 8'h02);
    #1 chk(drive.short_current, 1'b1);
    @(posedge clk);
    sense.below_short <= 1'b0;
    step(3);
    cs(8'h07, 8'h03);
    step(HOLD + 5 * STEP);
    #1 chk(drive.ilim_pct, 7'h64);
    cs(8'h40, 8'h40);
    $display("test start done");
    // each blocker in turn holds termination off
    for (int i = 0; i < 10; i++)
    begin
      sense <= base ^ (i < 6 ? 12'h40 >> i : 12'(i == 9));
      ilim <= (i == 6) ? 3'h0 : 3'h5;
      if (i > 6)
        u_ccseq_host.wr(`CCSEQ_ADDR_CTRL, i == 7 ? 8'h14 : i == 8 ? 8'h00
          : `CCSEQ_CTRL_RST_VAL);
      step(TERM + 2 + $urandom % 8);
      #1 chk({drive.thermal_fold, drive.supplement_mode},
        {i == 0, i == 1});
      cs(8'h07, 8'h03);
    end
    sense <= base;
    u_ccseq_host.wr(`CCSEQ_ADDR_CTRL, `CCSEQ_CTRL_RST_VAL);
    step(TERM + 6);
    cs(8'h07, 8'h05);
    #1 chk({drive.sys_reg_mode, drive.charge_fet}, 2'b10);
    @(posedge clk);
    sense <= 12'hA00;
    step(2);
    cs(8'h07, 8'h01);
    $display("test termination done");
    // fault cleared by a low battery, then by high impedance
    for (int k = 0; k < 2; k++)
    begin
      sense <= 12'h880;
      step(2);
      #1 chk({drive.pwm_on, drive.batt_fet}, 2'b01);
      step(OVP + 2);
      cs(8'h87, 8'h86);
      sense <= k ? 12'h800 : 12'hA00;
      pin <= k;
      step(3);
      cs(8'h80, 8'h00);
      pin <= 1'b0;
    end
    $display("test overvoltage done");
    // both ends of the code range and one drawn between
    for (int j = 0; j < 3; j++)
    begin
      e = j == 0 ? `CCSEQ_VREG_MIN : j == 1 ? `CCSEQ_VREG_MAX
        : 8'($urandom_range(`CCSEQ_VREG_MAX, `CCSEQ_VREG_MIN));
      u_ccseq_host.set_vreg(e);
      u_ccseq_host.rd(`CCSEQ_ADDR_VREG, got);
      chk(got, e);
      chk(vreg, e);
    end
    $display("test regulation done");
    conclude();
  end
endmodule
bind ccseq_top ccseq_top_asserts #(.SS_STEP_CYC(SS_STEP_CYC),
  .TERM_CYC(TERM_CYC), .OVP_CYC(OVP_CYC)) u_ccseq_top_asserts (.CLOCK,
  .RST_N, .CE, .WR, .CHARGE_INHIBIT_PIN, .ILIM_SEL, .SENSE, .DRIVE,
  .BATTERY_OVERVOLTAGE_FAULT);
